// >>> verilog/home_ctrl.sv
// Contract
// - Gain query answers at once, encoder stepper single
// - High polarity command makes high the home
// - Low polarity command; low default unless saved high
// - Multi mode empty argument keeps axis polarity
// - Home runs axis positive at set velocity
// - Switch mode uses home input only
// - On home load position, ramp to stop
// - Single no parameter loads zero; multi selects axes
// - Speed at update rate gives exact position
// - Home uses three command, one/eleven argument entries
// - Power auto and settle time add entries
// - After vector/contour move add restore entries
// - Encoder home needs index, A high, B low
`timescale 1ns/1ps
`default_nettype none
`include "home_cfg.svh"

module home_ctrl #(
  parameter int UPD_CYCLES = `UPD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  input wire home_pkg::cmd_t cmd_op,
  input wire logic multi_mode,
  input wire logic [1:0] axis_sel,
  input wire logic [3:0] arg_present,
  input wire logic [127:0] arg_val,
  // Axis configuration
  input wire logic [3:0] axis_stepper,
  input wire logic [3:0] axis_encoder,
  input wire logic [3:0] encoder_qualified_homing_mode,
  input wire logic [3:0] save_power_up_defaults,
  input wire logic [95:0] velocity_setting,
  input wire logic [127:0] acceleration_setting,
  // Queue accounting conditions
  input wire logic automatic_power_mode,
  input wire logic settle_time_set,
  input wire logic last_vector_or_contour,
  input wire home_pkg::ramp_t ramp_type,
  input wire logic [7:0] ramp_segments,
  // Axis pins
  input wire logic [3:0] home_pin,
  input wire logic [3:0] index_pin,
  input wire logic [3:0] phase_a_pin,
  input wire logic [3:0] phase_b_pin,
  // Status
  output logic [3:0] home_polarity_high,
  output logic [127:0] position,
  output logic [3:0] axis_busy,
  output logic [3:0] home_found,
  output logic report_valid,
  output logic report_err,
  output logic [15:0] report_hold_gain,
  output logic [7:0] cmdq_used,
  output logic [9:0] argq_used
);

  ////////////////////////////////////////////////////////////////////////
  // Update pacing: one-cycle enable per motion update
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    if (tick_cnt_r >= 32'(UPD_CYCLES - 1)) begin
      tick_cnt_nxt = 32'h0000_0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode: polarity, gain, report and home start
  logic init_r, init_nxt;
  logic [3:0] pol_r, pol_nxt;
  logic [15:0] gain_r [4];
  logic [15:0] gain_nxt [4];
  logic [3:0] start_r, start_nxt;
  logic [31:0] load_r [4];
  logic [31:0] load_nxt [4];
  logic rep_v_r, rep_v_nxt;
  logic rep_e_r, rep_e_nxt;
  logic [15:0] rep_g_r, rep_g_nxt;
  logic [3:0] addr;
  logic [15:0] cur_gain;

  assign cur_gain = gain_r[axis_sel];

  always_comb begin
    init_nxt = 1'b1;
    pol_nxt = pol_r;
    start_nxt = 4'h0;
    rep_v_nxt = 1'b0;
    rep_e_nxt = 1'b0;
    rep_g_nxt = rep_g_r;
    // Multi-axis modes address by argument position
    addr = multi_mode ? arg_present : (4'h1 << axis_sel);
    for (int i = 0; i < `NAX; i++) begin
      gain_nxt[i] = gain_r[i];
      load_nxt[i] = load_r[i];
    end
    if (!init_r) begin
      // Saved power-up level taken just after reset release
      pol_nxt = save_power_up_defaults;
    end else if (cmd_valid) begin
      case (cmd_op)
        home_pkg::OP_REPORT_HOLD_GAIN: begin
          rep_v_nxt = 1'b1;
          if (!multi_mode && axis_stepper[axis_sel] &&
              axis_encoder[axis_sel]) begin
            rep_g_nxt = cur_gain;
          end else begin
            rep_e_nxt = 1'b1;
          end
        end
        home_pkg::OP_HOLD_GAIN_SET: begin
          for (int i = 0; i < `NAX; i++) begin
            if (addr[i]) begin
              gain_nxt[i] = arg_val[i*32 +: 16];
            end
          end
        end
        home_pkg::OP_POLARITY_HIGH: begin
          pol_nxt = pol_r | addr;
        end
        home_pkg::OP_POLARITY_LOW: begin
          pol_nxt = pol_r & ~addr;
        end
        home_pkg::OP_HOME_FORWARD: begin
          start_nxt = addr;
          for (int i = 0; i < `NAX; i++) begin
            if (addr[i]) begin
              load_nxt[i] = arg_present[i] ? arg_val[i*32 +: 32]
                                           : 32'h0000_0000;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_r <= 1'b0;
      pol_r <= 4'h0;
      start_r <= 4'h0;
      rep_v_r <= 1'b0;
      rep_e_r <= 1'b0;
      rep_g_r <= 16'h0000;
      for (int i = 0; i < `NAX; i++) begin
        gain_r[i] <= `GAIN_RST;
        load_r[i] <= 32'h0000_0000;
      end
    end else begin
      init_r <= init_nxt;
      pol_r <= pol_nxt;
      start_r <= start_nxt;
      rep_v_r <= rep_v_nxt;
      rep_e_r <= rep_e_nxt;
      rep_g_r <= rep_g_nxt;
      for (int i = 0; i < `NAX; i++) begin
        gain_r[i] <= gain_nxt[i];
        load_r[i] <= load_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue usage of each accepted home command
  logic [7:0] cq_r, cq_nxt;
  logic [9:0] aq_r, aq_nxt;
  logic home_cmd;

  assign home_cmd = init_r && cmd_valid &&
                    cmd_op == home_pkg::OP_HOME_FORWARD;

  always_comb begin
    cq_nxt = cq_r;
    aq_nxt = aq_r;
    if (home_cmd) begin
      cq_nxt = `CMDQ_HOME;
      aq_nxt = multi_mode ? `ARGQ_MULTI : `ARGQ_SINGLE;
      if (|(addr & (axis_encoder | ~axis_stepper))) begin
        aq_nxt = aq_nxt + `ARGQ_ENC;
      end
      if (automatic_power_mode) begin
        cq_nxt = cq_nxt + `CMDQ_PA;
      end
      if (settle_time_set) begin
        cq_nxt = cq_nxt + `CMDQ_SETTLE;
        aq_nxt = aq_nxt + `ARGQ_SETTLE;
      end
      // Restoring accel and velocity costs per ramp type
      if (last_vector_or_contour) begin
        case (ramp_type)
          home_pkg::RAMP_LINEAR: begin
            cq_nxt = cq_nxt + `CMDQ_RESTORE;
            aq_nxt = aq_nxt + `ARGQ_LINEAR;
          end
          home_pkg::RAMP_SHORT_PARAB: begin
            cq_nxt = cq_nxt + `CMDQ_RESTORE;
            aq_nxt = aq_nxt + `ARGQ_SHORT_PARAB;
          end
          home_pkg::RAMP_CUSTOM: begin
            cq_nxt = cq_nxt + `CMDQ_RESTORE;
            aq_nxt = aq_nxt + {1'b0, ramp_segments, 1'b0} +
                     `ARGQ_CUSTOM_BASE;
          end
          home_pkg::RAMP_SCURVE: begin
            cq_nxt = cq_nxt + `CMDQ_RESTORE_S;
            aq_nxt = aq_nxt + `ARGQ_SCURVE;
          end
          default: begin
            cq_nxt = cq_nxt + `CMDQ_RESTORE;
            aq_nxt = aq_nxt + `ARGQ_PARAB;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cq_r <= 8'h00;
      aq_r <= 10'h000;
    end else begin
      cq_r <= cq_nxt;
      aq_r <= aq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Axes
  genvar g;
  generate
    for (g = 0; g < `NAX; g++) begin : gen_axis
      home_axis u_axis (
        .clk(clk),
        .rst(rst),
        .tick(tick_r),
        .start(start_r[g]),
        .load_val(load_r[g]),
        .pol_high(pol_r[g]),
        .enc_mode(encoder_qualified_homing_mode[g]),
        .vel(velocity_setting[g*24 +: 24]),
        .accel(acceleration_setting[g*32 +: 32]),
        .home_pin(home_pin[g]),
        .idx_pin(index_pin[g]),
        .a_pin(phase_a_pin[g]),
        .b_pin(phase_b_pin[g]),
        .pos(position[g*32 +: 32]),
        .busy(axis_busy[g]),
        .found(home_found[g])
      );
    end
  endgenerate

  assign home_polarity_high = pol_r;
  assign report_valid = rep_v_r;
  assign report_err = rep_e_r;
  assign report_hold_gain = rep_g_r;
  assign cmdq_used = cq_r;
  assign argq_used = aq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence report_ok_s;
    init_r && cmd_valid && cmd_op == home_pkg::OP_REPORT_HOLD_GAIN &&
      !multi_mode && axis_stepper[axis_sel] && axis_encoder[axis_sel];
  endsequence

  chk_report_now: assert property (@(posedge clk) disable iff (rst)
    report_ok_s |=> report_valid && !report_err &&
      report_hold_gain == $past(cur_gain))
    else $error("gain report wrong");

  chk_report_multi: assert property (@(posedge clk) disable iff (rst)
    (init_r && cmd_valid && cmd_op == home_pkg::OP_REPORT_HOLD_GAIN &&
     multi_mode) |=> report_valid && report_err)
    else $error("multi gain report accepted");

  chk_pol_high: assert property (@(posedge clk) disable iff (rst)
    (init_r && cmd_valid && cmd_op == home_pkg::OP_POLARITY_HIGH &&
     !multi_mode) |=> home_polarity_high[$past(axis_sel)])
    else $error("high polarity not set");

  chk_pol_low: assert property (@(posedge clk) disable iff (rst)
    (init_r && cmd_valid && cmd_op == home_pkg::OP_POLARITY_LOW &&
     !multi_mode) |=> !home_polarity_high[$past(axis_sel)])
    else $error("low polarity not set");

  chk_pol_keep: assert property (@(posedge clk) disable iff (rst)
    (init_r && cmd_valid && multi_mode && arg_present == 4'h0)
      |=> $stable(home_polarity_high))
    else $error("empty argument changed polarity");

  chk_home_zero: assert property (@(posedge clk) disable iff (rst)
    (home_cmd && !multi_mode && !arg_present[axis_sel])
      |=> load_r[$past(axis_sel)] == 32'h0000_0000)
    else $error("default home value not zero");

  chk_queue_base: assert property (@(posedge clk) disable iff (rst)
    (home_cmd && !multi_mode && !automatic_power_mode &&
     !settle_time_set && !last_vector_or_contour &&
     axis_stepper[axis_sel] && !axis_encoder[axis_sel])
      |=> cmdq_used == 8'h03 && argq_used == 10'h001)
    else $error("base queue usage wrong");

  chk_queue_extra: assert property (@(posedge clk) disable iff (rst)
    (home_cmd && multi_mode && automatic_power_mode && settle_time_set &&
     !last_vector_or_contour && (arg_present & axis_encoder) == 4'h0 &&
     (arg_present & ~axis_stepper) == 4'h0)
      |=> cmdq_used == 8'h07 && argq_used == 10'h00C)
    else $error("extra queue usage wrong");

  chk_queue_scurve: assert property (@(posedge clk) disable iff (rst)
    (home_cmd && !multi_mode && !automatic_power_mode &&
     !settle_time_set && last_vector_or_contour &&
     ramp_type == home_pkg::RAMP_SCURVE && axis_stepper[axis_sel] &&
     !axis_encoder[axis_sel])
      |=> cmdq_used == 8'h0C && argq_used == 10'h069)
    else $error("restore queue usage wrong");

endmodule
`default_nettype wire

// >>> verilog/home_cfg.svh
`ifndef HOME_CFG_SVH
`define HOME_CFG_SVH

// Axis count and data widths
`define NAX 4
`define FRAC_BITS 10

// Clock and motion update rate
`define CLK_HZ 200000000
`define UPD_RATE_HZ 1024
`define UPD_CYCLES (`CLK_HZ / `UPD_RATE_HZ)

// Reset values
`define GAIN_RST 16'h0001

// Queue usage of a home command
`define CMDQ_HOME 8'h03
`define ARGQ_SINGLE 10'h001
`define ARGQ_MULTI 10'h00B
`define ARGQ_ENC 10'h002
`define CMDQ_PA 8'h02
`define CMDQ_SETTLE 8'h02
`define ARGQ_SETTLE 10'h001
`define CMDQ_RESTORE 8'h04
`define CMDQ_RESTORE_S 8'h09
`define ARGQ_LINEAR 10'h004
`define ARGQ_SHORT_PARAB 10'h006
`define ARGQ_PARAB 10'h016
`define ARGQ_SCURVE 10'h068
`define ARGQ_CUSTOM_BASE 10'h002

`endif

// >>> verilog/home_pkg.sv
package home_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_REPORT_HOLD_GAIN,
    OP_HOLD_GAIN_SET,
    OP_POLARITY_HIGH,
    OP_POLARITY_LOW,
    OP_HOME_FORWARD
  } cmd_t;

  typedef enum logic [2:0] {
    RAMP_LINEAR,
    RAMP_SHORT_PARAB,
    RAMP_PARAB,
    RAMP_COSINE,
    RAMP_CUSTOM,
    RAMP_SCURVE
  } ramp_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEEK,
    ST_STOP
  } axis_state_t;

endpackage

// >>> verilog/home_axis.sv
`timescale 1ns/1ps
`default_nettype none
`include "home_cfg.svh"

module home_axis (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pacing and control
  input wire logic tick,
  input wire logic start,
  input wire logic [31:0] load_val,
  input wire logic pol_high,
  input wire logic enc_mode,
  input wire logic [23:0] vel,
  input wire logic [31:0] accel,
  // Pins
  input wire logic home_pin,
  input wire logic idx_pin,
  input wire logic a_pin,
  input wire logic b_pin,
  // Status
  output logic [31:0] pos,
  output logic busy,
  output logic found
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic home_true;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= {home_pin, idx_pin, a_pin, b_pin};
      s2_r <= s1_r;
    end
  end

  // Switch mode looks only at the home input
  assign home_true = (s2_r[3] == pol_high) &&
                     (!enc_mode || (s2_r[2] && s2_r[1] && !s2_r[0]));

  ////////////////////////////////////////////////////////////////////////
  // Motion state: position and speed carry fractional update bits
  home_pkg::axis_state_t st_r, st_nxt;
  logic [41:0] pos_fx_r, pos_fx_nxt;
  logic [33:0] vel_fx_r, vel_fx_nxt;
  logic found_r, found_nxt;
  logic busy_r, busy_nxt;
  logic [41:0] step_fx;

  assign step_fx = {8'h00, vel_fx_r};

  always_comb begin
    st_nxt = st_r;
    pos_fx_nxt = pos_fx_r;
    vel_fx_nxt = vel_fx_r;
    found_nxt = 1'b0;
    case (st_r)
      home_pkg::ST_IDLE: begin
        if (start) begin
          st_nxt = home_pkg::ST_SEEK;
          vel_fx_nxt = {vel, 10'h000};
        end
      end
      home_pkg::ST_SEEK: begin
        // Home is judged once per update, first true one wins
        if (tick) begin
          if (home_true) begin
            pos_fx_nxt = {load_val, 10'h000};
            st_nxt = home_pkg::ST_STOP;
            found_nxt = 1'b1;
          end else begin
            // At most one whole step per update below the update rate
            pos_fx_nxt = pos_fx_r + (step_fx >> `FRAC_BITS);
          end
        end
      end
      home_pkg::ST_STOP: begin
        if (tick) begin
          pos_fx_nxt = pos_fx_r + (step_fx >> `FRAC_BITS);
          if (vel_fx_r <= {2'b00, accel}) begin
            vel_fx_nxt = 34'h0_0000_0000;
            st_nxt = home_pkg::ST_IDLE;
          end else begin
            vel_fx_nxt = vel_fx_r - {2'b00, accel};
          end
        end
      end
      default: st_nxt = home_pkg::ST_IDLE;
    endcase
    busy_nxt = (st_nxt != home_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= home_pkg::ST_IDLE;
      pos_fx_r <= 42'h000_0000_0000;
      vel_fx_r <= 34'h0_0000_0000;
      found_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pos_fx_r <= pos_fx_nxt;
      vel_fx_r <= vel_fx_nxt;
      found_r <= found_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign pos = pos_fx_r[41:10];
  assign busy = busy_r;
  assign found = found_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence detect_s;
    st_r == home_pkg::ST_SEEK && tick && home_true;
  endsequence

  chk_home_load: assert property (@(posedge clk) disable iff (rst)
    detect_s |=> (pos == $past(load_val)) && (st_r == home_pkg::ST_STOP))
    else $error("home load value wrong");

  chk_seek_fwd: assert property (@(posedge clk) disable iff (rst)
    (st_r == home_pkg::ST_SEEK && !(tick && home_true))
      |=> pos_fx_r >= $past(pos_fx_r))
    else $error("seek moved backward");

  chk_switch_only: assert property (@(posedge clk) disable iff (rst)
    (st_r == home_pkg::ST_SEEK && tick && !enc_mode &&
     s2_r[3] == pol_high) |=> found_r)
    else $error("switch home missed");

  chk_enc_qual: assert property (@(posedge clk) disable iff (rst)
    (st_r == home_pkg::ST_SEEK && tick && enc_mode &&
     (!s2_r[2] || !s2_r[1] || s2_r[0])) |=> !found_r)
    else $error("encoder home without quadrant");

  chk_tick_only: assert property (@(posedge clk) disable iff (rst)
    found_r |-> $past(tick) && $past(st_r) == home_pkg::ST_SEEK)
    else $error("home acted off update");

  chk_exact_step: assert property (@(posedge clk) disable iff (rst)
    (st_r == home_pkg::ST_SEEK && vel_fx_r[33:10] <= 24'h00_0400 &&
     !(tick && home_true)) |=> (pos - $past(pos)) <= 32'h0000_0001)
    else $error("more than one step per update");

  chk_stop_end: assert property (@(posedge clk) disable iff (rst)
    (st_r == home_pkg::ST_STOP && tick && vel_fx_r <= {2'b00, accel})
      |=> st_r == home_pkg::ST_IDLE && !busy_r)
    else $error("stop ramp did not end");

endmodule
`default_nettype wire

// >>> bench/axis_plant.sv
`timescale 1ns/1ps
`default_nettype none

// Stage model: a home switch per axis and an encoder that follows the
// position counter, so encoder qualification sees real quadrature.
module axis_plant (
  // Motion state
  input wire logic [127:0] position,
  // Switch state set by the bench
  input wire logic [3:0] switch_closed,
  input wire logic [3:0] switch_active_high,
  // Pins
  output logic [3:0] home_pin,
  output logic [3:0] index_pin,
  output logic [3:0] phase_a_pin,
  output logic [3:0] phase_b_pin
);

  ////////////////////////////////////////////////////////////////////////
  // The switch drives its own electrical level; the controller must be
  // told that level by its polarity setting
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      home_pin[i] = switch_closed[i] ~^ switch_active_high[i];
      phase_a_pin[i] = position[i*32] ^ position[i*32+1];
      phase_b_pin[i] = position[i*32+1];
      index_pin[i] = (position[i*32+2 +: 3] == 3'h0);
    end
  end

endmodule

`default_nettype wire

// >>> bench/axis_home_search_and_polarity_tb.sv
`timescale 1ns/1ps
`default_nettype none

module axis_home_search_and_polarity_tb;
  localparam int UPD = 16;

  typedef struct packed {
    logic pa;
    logic st;
    logic lv;
    home_pkg::ramp_t rt;
    logic [7:0] sg;
    logic [7:0] c;
    logic [9:0] a;
  } qcase_t;

  logic clk;
  logic rst;
  logic cmd_valid;
  home_pkg::cmd_t cmd_op;
  logic multi_mode;
  logic [1:0] axis_sel;
  logic [3:0] arg_present;
  logic [127:0] arg_val;
  logic [3:0] enc_mode;
  logic pa;
  logic settle;
  logic last_vc;
  home_pkg::ramp_t ramp;
  logic [7:0] segs;
  logic [3:0] sw_closed;
  logic [3:0] home_pin;
  logic [3:0] index_pin;
  logic [3:0] phase_a_pin;
  logic [3:0] phase_b_pin;
  logic [3:0] pol;
  logic [127:0] position;
  logic [3:0] axis_busy;
  logic [3:0] home_found;
  logic report_valid;
  logic report_err;
  logic [15:0] gain;
  logic [7:0] cmdq;
  logic [9:0] argq;
  int err_count;
  int n_tests;
  logic ok;
  logic [31:0] p0;
  logic [31:0] p1;
  logic [31:0] prev;
  qcase_t qtab [9];

  ////////////////////////////////////////////////////////////////////////
  // Axis 0 servo, axes 1-2 stepper with encoder, axis 3 plain stepper
  home_ctrl #(.UPD_CYCLES(UPD)) uut (
    .clk(clk),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_op(cmd_op),
    .multi_mode(multi_mode),
    .axis_sel(axis_sel),
    .arg_present(arg_present),
    .arg_val(arg_val),
    .axis_stepper(4'hE),
    .axis_encoder(4'h6),
    .encoder_qualified_homing_mode(enc_mode),
    .save_power_up_defaults(4'h4),
    .velocity_setting({4{24'h00_0400}}),
    .acceleration_setting({4{32'h0004_0000}}),
    .automatic_power_mode(pa),
    .settle_time_set(settle),
    .last_vector_or_contour(last_vc),
    .ramp_type(ramp),
    .ramp_segments(segs),
    .home_pin(home_pin),
    .index_pin(index_pin),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin),
    .home_polarity_high(pol),
    .position(position),
    .axis_busy(axis_busy),
    .home_found(home_found),
    .report_valid(report_valid),
    .report_err(report_err),
    .report_hold_gain(gain),
    .cmdq_used(cmdq),
    .argq_used(argq)
  );

  axis_plant u_plant (
    .position(position),
    .switch_closed(sw_closed),
    .switch_active_high(4'hA),
    .home_pin(home_pin),
    .index_pin(index_pin),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  function automatic logic [31:0] pos(input int ax);
    return position[ax*32 +: 32];
  endfunction

  // Strobe held for exactly one edge; returns at the taking edge
  task automatic issue(input home_pkg::cmd_t op, input logic mm,
      input logic [1:0] sel, input logic [3:0] pres,
      input logic [127:0] val);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    multi_mode <= mm;
    axis_sel <= sel;
    arg_present <= pres;
    arg_val <= val;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic report(input logic [1:0] sel, input logic mm,
      input logic e, input logic [15:0] g);
    issue(home_pkg::OP_REPORT_HOLD_GAIN, mm, sel, 4'h0, '0);
    // The answer pulse stands only in the cycle after the taking edge
    #1;
    chk(report_valid, 1'b1);
    chk(report_err, e);
    if (!e) begin
      chk(gain, g);
    end
  endtask

  task automatic pol_cmd(input home_pkg::cmd_t op, input logic mm,
      input logic [1:0] sel, input logic [3:0] pres, input logic [3:0] e);
    issue(op, mm, sel, pres, '0);
    @(posedge clk);
    #1;
    chk(pol, e);
  endtask

  task automatic wait_idle(input int ax);
    int n;
    n = 0;
    while (n < 400 && axis_busy[ax] !== 1'b0) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 400, 1'b1);
  endtask

  // Also keeps the position seen one cycle before the detection pulse
  task automatic wait_found(input int ax, input int lim, output logic f,
      output logic [31:0] p, output logic [31:0] pv);
    int n;
    n = 0;
    #1;
    pv = pos(ax);
    while (n < lim && home_found[ax] !== 1'b1) begin
      pv = pos(ax);
      @(posedge clk);
      #1;
      n++;
    end
    f = (home_found[ax] === 1'b1);
    p = pos(ax);
  endtask

  task automatic home_q(input logic mm, input logic [1:0] ax,
      input logic [3:0] pres, input logic [127:0] val,
      input logic [7:0] c, input logic [9:0] a);
    issue(home_pkg::OP_HOME_FORWARD, mm, ax, pres, val);
    @(posedge clk);
    #1;
    chk(cmdq, c);
    chk(argq, a);
    @(posedge clk);
    #1;
    chk(axis_busy, 4'h1 << ax);
    wait_idle(ax);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = home_pkg::OP_NONE;
    multi_mode = 1'b0;
    axis_sel = 2'h0;
    arg_present = 4'h0;
    arg_val = '0;
    enc_mode = 4'h0;
    pa = 1'b0;
    settle = 1'b0;
    last_vc = 1'b0;
    ramp = home_pkg::RAMP_LINEAR;
    segs = 8'h00;
    sw_closed = 4'h0;
    err_count = 0;
    n_tests = 0;
    qtab = '{
      '{1'b0, 1'b0, 1'b0, home_pkg::RAMP_LINEAR, 8'h00, 8'h03, 10'h001},
      '{1'b1, 1'b0, 1'b0, home_pkg::RAMP_LINEAR, 8'h00, 8'h05, 10'h001},
      '{1'b0, 1'b1, 1'b0, home_pkg::RAMP_LINEAR, 8'h00, 8'h05, 10'h002},
      '{1'b0, 1'b0, 1'b1, home_pkg::RAMP_LINEAR, 8'h00, 8'h07, 10'h005},
      '{1'b0, 1'b0, 1'b1, home_pkg::RAMP_SHORT_PARAB, 8'h00, 8'h07, 10'h007},
      '{1'b0, 1'b0, 1'b1, home_pkg::RAMP_PARAB, 8'h00, 8'h07, 10'h017},
      '{1'b0, 1'b0, 1'b1, home_pkg::RAMP_COSINE, 8'h00, 8'h07, 10'h017},
      '{1'b0, 1'b0, 1'b1, home_pkg::RAMP_CUSTOM, 8'h05, 8'h07, 10'h00D},
      '{1'b1, 1'b1, 1'b1, home_pkg::RAMP_SCURVE, 8'h00, 8'h10, 10'h06A}
    };
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(pol, 4'h4);
    report(2'h1, 1'b0, 1'b0, 16'h0001);
    $display("reset defaults test done");

    issue(home_pkg::OP_HOLD_GAIN_SET, 1'b0, 2'h1, 4'hF, {4{32'h0000_0064}});
    report(2'h1, 1'b0, 1'b0, 16'h0064);
    report(2'h3, 1'b0, 1'b1, 16'h0000);
    report(2'h0, 1'b0, 1'b1, 16'h0000);
    report(2'h1, 1'b1, 1'b1, 16'h0000);
    $display("gain report test done");

    pol_cmd(home_pkg::OP_POLARITY_HIGH, 1'b0, 2'h0, 4'h0, 4'h5);
    pol_cmd(home_pkg::OP_POLARITY_LOW, 1'b0, 2'h2, 4'h0, 4'h1);
    pol_cmd(home_pkg::OP_POLARITY_HIGH, 1'b1, 2'h0, 4'hA, 4'hB);
    pol_cmd(home_pkg::OP_POLARITY_LOW, 1'b1, 2'h0, 4'h1, 4'hA);
    $display("polarity test done");

    // Closed switches make every home finish within a few ticks
    @(posedge clk);
    sw_closed <= 4'hF;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      pa <= qtab[i].pa;
      settle <= qtab[i].st;
      last_vc <= qtab[i].lv;
      ramp <= qtab[i].rt;
      segs <= qtab[i].sg;
      home_q(1'b0, 2'h3, 4'h0, '0, qtab[i].c, qtab[i].a);
    end
    @(posedge clk);
    last_vc <= 1'b0;
    home_q(1'b1, 2'h3, 4'h8, '0, 8'h07, 10'h00C);
    @(posedge clk);
    pa <= 1'b0;
    settle <= 1'b0;
    last_vc <= 1'b0;
    home_q(1'b0, 2'h0, 4'h0, '0, 8'h03, 10'h003);
    home_q(1'b1, 2'h3, 4'h8, {32'h0000_2000, 96'h0}, 8'h03, 10'h00B);
    $display("queue usage test done");

    @(posedge clk);
    sw_closed <= 4'h7;
    issue(home_pkg::OP_HOME_FORWARD, 1'b0, 2'h3, 4'h0, {4{32'h0000_1234}});
    repeat (2) @(posedge clk);
    #1;
    p0 = pos(3);
    repeat (10 * UPD) @(posedge clk);
    #1;
    chk(pos(3) > p0 && axis_busy[3] === 1'b1, 1'b1);
    @(posedge clk);
    sw_closed <= 4'hF;
    wait_found(3, UPD + 6, ok, p1, prev);
    chk(ok, 1'b1);
    chk(p1, 32'h0000_0000);
    wait_idle(3);
    chk(pos(3) > 32'h0 && pos(3) < 32'h8, 1'b1);
    issue(home_pkg::OP_HOME_FORWARD, 1'b0, 2'h3, 4'hF, {4{32'h0000_1000}});
    wait_found(3, 2 * UPD + 8, ok, p1, prev);
    chk(p1, 32'h0000_1000);
    wait_idle(3);
    $display("home search test done");

    @(posedge clk);
    enc_mode <= 4'h2;
    sw_closed <= 4'hD;
    issue(home_pkg::OP_HOME_FORWARD, 1'b0, 2'h1, 4'h0, '0);
    @(posedge clk);
    #1;
    chk(argq, 10'h003);
    wait_found(1, 40 * UPD, ok, p1, prev);
    chk(ok, 1'b0);
    @(posedge clk);
    sw_closed <= 4'hF;
    wait_found(1, 40 * UPD, ok, p1, prev);
    chk(ok, 1'b1);
    chk(prev[4:2], 3'h0);
    wait_idle(1);
    $display("encoder home test done");
    report_and_stop();
  end

  // A hung handshake ends the run here instead of spinning forever
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

endmodule

`default_nettype wire
